// *** hdl/timer_pwm_flag_contention.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_flag_contention
	import timer_pwm_pkg::*;
#(
	parameter bit A_MASK = 1'b0                         // 0 base silicon, 1 revised
)
(
	input  wire logic              clk_in,                          // 40 MHz clock
	input  wire logic              reset_in,                        // async reset, high
	input  wire logic [1:0]        mode_in,                         // mode_t code
	input  wire logic              ch3_start_bit_in,                // ch3 run
	input  wire logic              ch4_start_bit_in,                // ch4 run, normal only
	input  wire logic [CTRL_W-1:0] ch3_control_register_in,         // ch3 clock and clear
	input  wire logic [CTRL_W-1:0] ch4_control_register_in,         // ch4 clock and clear
	input  wire logic              ch3_sync_bit_in,                 // ch3 sync operation
	input  wire logic              ch4_sync_bit_in,                 // ch4 sync operation
	input  wire logic [CNT_W-1:0]  ch3_period_register_in,          // period compare
	input  wire logic [CNT_W-1:0]  ch4_compare_in,                  // ch4 clear compare
	input  wire logic [CNT_W-1:0]  ch3_duty_register_in,            // pwm duty
	input  wire logic [CNT_W-1:0]  ch3_duty_buffer_in,              // duty buffer value
	input  wire logic [CNT_W-1:0]  dead_time_value_in,              // dead time
	input  wire logic              ch3_wr_in,                       // ch3 write, T2 pulse
	input  wire logic              ch4_wr_in,                       // ch4 write, T2 pulse
	input  wire logic [CNT_W-1:0]  wr_data_in,                      // counter write data
	input  wire logic [7:0]        ch3_io_control_high_in,          // pin 3B in [7:4]
	input  wire logic [7:0]        ch3_io_control_low_in,           // pin 3D in [7:4]
	input  wire logic [7:0]        ch4_io_control_high_in,          // pins 4A, 4B
	input  wire logic [7:0]        ch4_io_control_low_in,           // pins 4C, 4D
	input  wire logic              positive_phase_level_select_in,  // 1 high active
	input  wire logic              negative_phase_level_select_in,  // 1 high active
	input  wire logic              chop_en_in,                      // chopping on
	input  wire logic              chop_carrier_in,                 // chopping carrier
	input  wire logic [FLAG_W-1:0] flag_clear_in,                   // flag clear pulses
	output logic      [CNT_W-1:0]  ch3_counter_out,                 // ch3 count
	output logic      [CNT_W-1:0]  ch4_counter_out,                 // ch4 count
	output logic      [CNT_W-1:0]  dead_time_subcounter_out,        // dead-time count
	output logic      [1:0]        overflow_flag_out,               // [0] ch3, [1] ch4
	output logic      [1:0]        underflow_flag_out,              // [0] ch3, [1] ch4
	output logic                   buf_match_flag_out,              // buffer match
	output logic      [PIN_N-1:0]  pins_out,                        // pin levels
	output logic      [PIN_N-1:0]  pins_oe_n_out                    // low while driving
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [CNT_W-1:0]   ch3_q, ch4_q, sub_q;     // counters
	logic [PRESC_W-1:0] presc_q;                 // shared prescaler
	logic               tap3_q, tap4_q;          // previous tap levels
	logic               dir_q;                   // 1 counting down (complementary)
	logic               ovf3_q, ovf4_q, unf3_q, unf4_q, bufm_q;
	logic               rsync_act_q;             // reset-sync active phase
	logic [PIN_N-1:0]   pin_q, oe_n_q;

	// prescaler tap for a clock select code
	function automatic logic tap_of(input logic [PRESC_W-1:0] p, input logic [1:0] sel);
		logic t;
		t = 1'b1;
		unique case (sel)
			CLK_DIV1:  t = 1'b1;
			CLK_DIV4:  t = p[TAP_DIV4];
			CLK_DIV16: t = p[TAP_DIV16];
			CLK_DIV64: t = p[TAP_DIV64];
		endcase
		return t;
	endfunction

	// ----------------------------------------------------------------
	// mode decode and count ticks
	// ----------------------------------------------------------------
	wire       normal = (mode_in == MODE_NORMAL);
	wire       compl  = (mode_in == MODE_COMPL);
	wire       rsync  = (mode_in == MODE_RSYNC);
	wire       pwm    = compl | rsync;
	wire [1:0] sel3   = ch3_control_register_in[CTRL_SEL_LSB +: 2];
	wire       edge3  = ch3_control_register_in[CTRL_EDGE_BIT];
	// paired modes borrow ch3 clocking for ch4
	wire [1:0] sel4   = pwm ? sel3 : ch4_control_register_in[CTRL_SEL_LSB +: 2];
	wire       edge4  = pwm ? edge3 : ch4_control_register_in[CTRL_EDGE_BIT];
	wire [1:0] src3   = ch3_control_register_in[CTRL_CLR_LSB +: 2];
	wire [1:0] src4   = ch4_control_register_in[CTRL_CLR_LSB +: 2];
	wire       tap3   = tap_of(presc_q, sel3);
	wire       tap4   = tap_of(presc_q, sel4);
	wire       tick3  = (sel3 == CLK_DIV1) | (edge3 ? (tap3_q & ~tap3) : (~tap3_q & tap3));
	wire       tick4  = (sel4 == CLK_DIV1) | (edge4 ? (tap4_q & ~tap4) : (~tap4_q & tap4));
	wire       run4   = pwm ? ch3_start_bit_in : ch4_start_bit_in;
	wire       cnt3_tick = ch3_start_bit_in & tick3;
	wire       cnt4_tick = run4 & tick4;

	// ----------------------------------------------------------------
	// clear sources, clearing on the final state of a match
	// ----------------------------------------------------------------
	wire match3    = (ch3_q == ch3_period_register_in);
	wire match4    = (ch4_q == ch4_compare_in);
	wire sync_pair = ch3_sync_bit_in & ch4_sync_bit_in;
	wire clr3_own  = cnt3_tick & match3 & (rsync | (normal & (src3 == CLR_PERIOD)));
	wire clr4_own  = cnt4_tick & match4 & normal & (src4 == CLR_PERIOD);
	// proper synchronous clear of ch4 from ch3, the software fix for overflow flags
	wire ch4_sync_clr = sync_pair & (src4 == CLR_SYNC) & (src3 == CLR_PERIOD) & clr3_own;
	wire clr3 = clr3_own | (sync_pair & (src3 == CLR_SYNC) & clr4_own);
	wire clr4 = clr4_own | (rsync & clr3_own) | ch4_sync_clr;

	// ----------------------------------------------------------------
	// complementary triangle direction and stop values
	// ----------------------------------------------------------------
	wire compl_stop = compl & ~ch3_start_bit_in;
	wire turn  = compl & cnt3_tick & (dir_q ? (ch3_q == dead_time_value_in) : match3);
	wire dir_d = (~compl | compl_stop) ? 1'b0 : (turn ? ~dir_q : dir_q);
	wire up    = ~dir_d;

	// ----------------------------------------------------------------
	// counter next values: clear, then write, then count
	// ----------------------------------------------------------------
	wire [CNT_W-1:0] ch3_step = up ? ch3_q + 16'h0001 : ch3_q - 16'h0001;   // wraps
	wire [CNT_W-1:0] ch4_step = up ? ch4_q + 16'h0001 : ch4_q - 16'h0001;
	wire [CNT_W-1:0] ch3_d = clr3 ? CNT_RESET : ch3_wr_in ? wr_data_in :
	                         compl_stop ? dead_time_value_in : cnt3_tick ? ch3_step : ch3_q;
	wire [CNT_W-1:0] ch4_d = clr4 ? CNT_RESET : ch4_wr_in ? wr_data_in :
	                         compl_stop ? CNT_RESET : cnt4_tick ? ch4_step : ch4_q;
	// dead-time subcounter restarts at each turn and stops at the dead time
	wire [CNT_W-1:0] sub_d = (~compl | turn) ? CNT_RESET :
	                         (cnt3_tick & (sub_q < dead_time_value_in)) ? sub_q + 16'h0001 : sub_q;

	// ----------------------------------------------------------------
	// overflow and underflow flags; a set always beats a software clear
	// ----------------------------------------------------------------
	wire ovf3_evt = cnt3_tick & up & (ch3_q == CNT_ALL_ONES);
	wire ovf4_evt = cnt4_tick & up & (ch4_q == CNT_ALL_ONES);
	wire unf3_evt = cnt3_tick & ~up & (ch3_q == CNT_RESET);
	wire unf4_evt = cnt4_tick & ~up & (ch4_q == CNT_RESET);
	// base silicon lets the ch4 flag through an unsynchronised reset-sync clear
	wire quirk4   = ~A_MASK & rsync & ~ch4_sync_clr;
	wire ovf3_set = ovf3_evt & ~clr3 & ~ch3_wr_in;
	wire ovf4_set = ovf4_evt & (~clr4 | quirk4) & ~ch4_wr_in;
	wire unf3_set = unf3_evt & ~clr3 & ~ch3_wr_in;
	wire unf4_set = unf4_evt & ~clr4 & ~ch4_wr_in;

	// ----------------------------------------------------------------
	// buffer compare match in complementary mode
	// ----------------------------------------------------------------
	wire [CNT_W-1:0] buf_v  = ch3_duty_buffer_in;
	wire [CNT_W-1:0] dead_v  = dead_time_value_in;              // one dead time
	wire [CNT_W-1:0] dead2_v = {dead_v[CNT_W-2:0], 1'b0};       // twice the dead time
	wire buf_hit  = cnt3_tick & ((buf_v == ch3_q) | (buf_v == ch4_q) | (buf_v == sub_q));
	// the base part misses these four values; the revised part has no gap
	wire buf_excl = (buf_v == dead_v) | (buf_v == dead2_v) |
	                (buf_v == ch3_period_register_in - dead_v) |
	                (buf_v == ch3_period_register_in - dead2_v);
	wire buf_set  = compl & buf_hit & (A_MASK | ~buf_excl);

	// ----------------------------------------------------------------
	// pwm levels, polarity and chopping
	// ----------------------------------------------------------------
	wire rsync_act_d = ~rsync ? 1'b0 : clr3_own ? 1'b1 :
	                   (cnt3_tick & (ch3_q == ch3_duty_register_in)) ? 1'b0 : rsync_act_q;
	wire pos_act  = rsync ? rsync_act_q : (ch3_q > ch3_duty_register_in);
	wire neg_act  = rsync ? ~rsync_act_q : (ch4_q < ch3_duty_register_in);
	wire gate     = ~chop_en_in | chop_carrier_in;
	wire pos_sel  = positive_phase_level_select_in;
	wire neg_sel  = negative_phase_level_select_in;
	// revised part chops the active phase then applies polarity
	wire pos_good = pos_sel ? (pos_act & gate) : ~(pos_act & gate);
	wire neg_good = neg_sel ? (neg_act & gate) : ~(neg_act & gate);
	// base part chops after polarity, wrong for low-active outputs
	wire pos_bad  = (pos_sel ? pos_act : ~pos_act) & gate;
	wire neg_bad  = (neg_sel ? neg_act : ~neg_act) & gate;
	wire pos_lvl  = A_MASK ? pos_good : pos_bad;
	wire neg_lvl  = A_MASK ? neg_good : neg_bad;
	wire [4*PIN_N-1:0] nib = {ch4_io_control_low_in[7:4], ch4_io_control_low_in[3:0],
	                          ch3_io_control_low_in[7:4], ch4_io_control_high_in[7:4],
	                          ch4_io_control_high_in[3:0], ch3_io_control_high_in[7:4]};

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// counters, prescaler and direction
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			ch3_q <= CNT_RESET;
			ch4_q <= CNT_RESET;
			sub_q <= CNT_RESET;
			presc_q <= PRESC_RESET;
			tap3_q <= 1'b0;
			tap4_q <= 1'b0;
			dir_q <= 1'b0;
			rsync_act_q <= 1'b0;
		end
		else
		begin
			ch3_q <= ch3_d;
			ch4_q <= ch4_d;
			sub_q <= sub_d;
			presc_q <= presc_q + 6'h01;
			tap3_q <= tap3;
			tap4_q <= tap4;
			dir_q <= dir_d;
			rsync_act_q <= rsync_act_d;
		end
	end

	// sticky flags; set wins over a clear in the same cycle
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			{ovf3_q, ovf4_q, unf3_q, unf4_q, bufm_q} <= 5'h00;
		end
		else
		begin
			ovf3_q <= ovf3_set | (ovf3_q & ~flag_clear_in[FLAG_OVF3]);
			ovf4_q <= ovf4_set | (ovf4_q & ~flag_clear_in[FLAG_OVF4]);
			unf3_q <= unf3_set | (unf3_q & ~flag_clear_in[FLAG_UNF3]);
			unf4_q <= unf4_set | (unf4_q & ~flag_clear_in[FLAG_UNF4]);
			bufm_q <= buf_set | (bufm_q & ~flag_clear_in[FLAG_BUF]);
		end
	end

	// per pin: i/o control in normal mode, pwm level while paired modes run
	for (genvar i = 0; i < PIN_N; i++)
	begin : g_pin
		wire [3:0] n   = nib[4*i +: 4];
		wire       lvl = (i < 3) ? pos_lvl : neg_lvl;
		always_ff @(posedge clk_in or posedge reset_in)
		begin
			if (reset_in)
			begin
				pin_q[i] <= PIN_RESET[i];
				oe_n_q[i] <= 1'b1;
			end
			else if (pwm)
			begin
				// i/o control ignored; level held until the pair runs, so a pin
				// released earlier keeps its stale level
				oe_n_q[i] <= 1'b0;
				if (ch3_start_bit_in)
					pin_q[i] <= lvl;
			end
			else
			begin
				// driven low/high by the nibble, released keeps the old level
				oe_n_q[i] <= (n != IO_LOW) & (n != IO_HIGH);
				if (n == IO_LOW)
					pin_q[i] <= 1'b0;
				else if (n == IO_HIGH)
					pin_q[i] <= 1'b1;
			end
		end
	end

	assign ch3_counter_out          = ch3_q;
	assign ch4_counter_out          = ch4_q;
	assign dead_time_subcounter_out = sub_q;
	assign overflow_flag_out        = {ovf4_q, ovf3_q};
	assign underflow_flag_out       = {unf4_q, unf3_q};
	assign buf_match_flag_out       = bufm_q;
	assign pins_out                 = pin_q;
	assign pins_oe_n_out            = oe_n_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_rsync_shared_start:
	assert property ((rsync && !ch3_start_bit_in && !ch4_wr_in) |=> $stable(ch4_counter_out))
		else $error("ch4 moved without ch3 start in reset-sync");
	a_base_ovf4_set:
	assert property ((!A_MASK && rsync && cnt3_tick && ch3_q == CNT_ALL_ONES && match3 &&
	                  ch4_q == CNT_ALL_ONES && !ch4_sync_clr && !ch4_wr_in && !ovf3_q)
	                 |=> overflow_flag_out == 2'b10 && ch4_counter_out == CNT_RESET)
		else $error("base reset-sync all-ones clear flags wrong");
	a_amask_no_ovf:
	assert property ((A_MASK && rsync && clr3_own && !ovf3_q && !ovf4_q)
	                 |=> overflow_flag_out == 2'b00)
		else $error("revised reset-sync clear set an overflow flag");
	a_buf_flag_cause:
	assert property ($rose(buf_match_flag_out) |-> $past(compl) && $past(cnt3_tick))
		else $error("buffer flag set outside complementary compare");
	a_base_dead_gap:
	assert property ((!A_MASK && compl && buf_v == dead_v && !bufm_q) |=> !buf_match_flag_out)
		else $error("base buffer flag set at dead-time value");
	a_amask_any_value:
	assert property ((A_MASK && compl && cnt3_tick && buf_v == ch3_q) |=> buf_match_flag_out)
		else $error("revised buffer flag missed");
	a_clear_beats_ovf:
	assert property ((clr3 && !ovf3_q && !unf3_q) |=> !overflow_flag_out[0] &&
	                 !underflow_flag_out[0] && ch3_counter_out == CNT_RESET)
		else $error("overflow flag set on clear");
	a_write_beats_ovf:
	assert property ((ch3_wr_in && !clr3 && !ovf3_q && !unf3_q) |=> !overflow_flag_out[0] &&
	                 !underflow_flag_out[0] && ch3_counter_out == $past(wr_data_in))
		else $error("write lost or flag set during write");
	a_final_state_clear:
	assert property ((normal && src3 == CLR_PERIOD && cnt3_tick && match3 && !clr4_own)
	                 |=> ch3_counter_out == CNT_RESET)
		else $error("compare clear not on final state");
	a_pwm_polarity:
	assert property ((pwm && ch3_start_bit_in && !chop_en_in)
	                 |=> pins_out[0] == ($past(pos_sel) ? $past(pos_act) : !$past(pos_act)))
		else $error("pwm polarity not from level select");
	a_base_low_chop:
	assert property ((!A_MASK && pwm && ch3_start_bit_in && chop_en_in && !chop_carrier_in)
	                 |=> pins_out[0] == 1'b0)
		else $error("base chopping output not gated low");
endmodule
`default_nettype wire

// *** hdl/timer_pwm_pkg.sv ***
`default_nettype none
package timer_pwm_pkg;
	// ----------------------------------------------------------------
	// widths and counter values
	// ----------------------------------------------------------------
	localparam int          CNT_W        = 16;       // counter and compare width
	localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF; // last value before overflow
	localparam logic [15:0] CNT_RESET    = 16'h0000; // counter value after reset or clear
	localparam int          PRESC_W      = 6;        // free prescaler width
	localparam logic [5:0]  PRESC_RESET  = 6'h00;    // prescaler after reset
	// ----------------------------------------------------------------
	// control register fields (clock select, edge, clear source)
	// ----------------------------------------------------------------
	localparam int         CTRL_W        = 5;     // control register width
	localparam int         CTRL_SEL_LSB  = 0;     // clock select, two bits
	localparam int         CTRL_EDGE_BIT = 2;     // 0 rising, 1 falling tap edge
	localparam int         CTRL_CLR_LSB  = 3;     // clear source, two bits
	localparam logic [1:0] CLK_DIV1      = 2'h0;  // count every clock
	localparam logic [1:0] CLK_DIV4      = 2'h1;  // count on prescaler bit 1
	localparam logic [1:0] CLK_DIV16     = 2'h2;  // count on prescaler bit 3
	localparam logic [1:0] CLK_DIV64     = 2'h3;  // count on prescaler bit 5
	localparam int         TAP_DIV4      = 1;     // prescaler tap positions
	localparam int         TAP_DIV16     = 3;
	localparam int         TAP_DIV64     = 5;
	localparam logic [1:0] CLR_NONE      = 2'h0;  // never cleared in normal mode
	localparam logic [1:0] CLR_PERIOD    = 2'h1;  // own compare match clears
	localparam logic [1:0] CLR_SYNC      = 2'h2;  // cleared with the partner channel
	// ----------------------------------------------------------------
	// flags, pins and i/o control nibbles
	// ----------------------------------------------------------------
	localparam int        FLAG_W    = 5;          // flag clear vector width
	localparam int        FLAG_OVF3 = 0;
	localparam int        FLAG_OVF4 = 1;
	localparam int        FLAG_UNF3 = 2;
	localparam int        FLAG_UNF4 = 3;
	localparam int        FLAG_BUF  = 4;
	localparam int        PIN_N     = 6;          // 3B 4A 4B positive, 3D 4C 4D negative
	localparam logic [3:0] IO_HIZ   = 4'h0;       // pin released
	localparam logic [3:0] IO_LOW   = 4'h1;       // pin driven low
	localparam logic [3:0] IO_HIGH  = 4'h2;       // pin driven high
	localparam logic [5:0] PIN_RESET = 6'h00;     // pins low after reset
	typedef enum logic [1:0] {MODE_NORMAL, MODE_COMPL, MODE_RSYNC} mode_t;
endpackage
`default_nettype wire

// *** test/timer_pwm_flag_contention_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_flag_contention_tb;
	import timer_pwm_pkg::*;
	// ----------------------------------------------------------------
	// inputs shared by both silicon variants
	// ----------------------------------------------------------------
	logic clk_in, reset_in, ch3_start_bit_in, ch4_start_bit_in;    // clock, reset, run bits
	logic ch3_sync_bit_in, ch4_sync_bit_in, ch3_wr_in, ch4_wr_in;  // sync and write pulses
	logic positive_phase_level_select_in, negative_phase_level_select_in; // polarity
	logic chop_en_in, chop_carrier_in;                             // chopping gate and carrier
	logic [1:0] mode_in;                                           // operating mode
	logic [4:0] ch3_control_register_in, ch4_control_register_in, flag_clear_in;
	logic [15:0] ch3_period_register_in, ch4_compare_in, ch3_duty_register_in;
	logic [15:0] ch3_duty_buffer_in, dead_time_value_in, wr_data_in;
	logic [7:0] ch3_io_control_high_in, ch3_io_control_low_in;     // pin nibbles
	logic [7:0] ch4_io_control_high_in, ch4_io_control_low_in;
	// outputs, index 0 base silicon, index 1 revised
	logic [15:0] c3_o [2], c4_o [2], sub_o [2], tally [2];
	logic [1:0]  ovf_o [2], unf_o [2];
	logic        buf_o [2];
	logic [5:0]  pin_o [2], oe_o [2];
	typedef struct { int sel; int v; logic [15:0] exp; } note_t;
	note_t notes [$];                                // expectations not yet compared
	event  seen_ev;                                  // result is ready to be compared
	int    fail_count = 0;
	int    comparisons = 0;
	string what [9] = '{"ch3", "ch4", "ovf", "buf", "pins", "oe_n", "unf", "tally", "sub"};
	for (genvar g = 0; g < 2; g++)
	begin : g_variant
		timer_pwm_flag_contention #(.A_MASK(g == 1)) timer_pwm_flag_contention_i
		(
			.*,
			.ch3_counter_out(c3_o[g]), .ch4_counter_out(c4_o[g]),
			.dead_time_subcounter_out(sub_o[g]), .overflow_flag_out(ovf_o[g]),
			.underflow_flag_out(unf_o[g]), .buf_match_flag_out(buf_o[g]),
			.pins_out(pin_o[g]), .pins_oe_n_out(oe_o[g])
		);
	end
	// ----------------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// a hang counts as a mismatch; the whole run needs under 2000 cycles
	initial
	begin
		#(25 * 5000);
		fail_count++;
		give_verdict();
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] obs(input int sel, input int v);
		case (sel)
			0: return c3_o[v];
			1: return c4_o[v];
			2: return {14'h0000, ovf_o[v]};
			3: return {15'h0000, buf_o[v]};
			4: return {10'h000, pin_o[v]};
			5: return {10'h000, oe_o[v]};
			6: return {14'h0000, unf_o[v]};
			7: return tally[v];
			default: return sub_o[v];
		endcase
	endfunction
	// note one expectation per variant, then wake the comparing process
	task automatic note(input int sel, input logic [15:0] e0, input logic [15:0] e1);
		notes.push_back('{sel, 0, e0});
		notes.push_back('{sel, 1, e1});
		->seen_ev;
		#1;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic wr(input logic w3, input logic w4, input logic [15:0] d);
		{ch3_wr_in, ch4_wr_in, wr_data_in} = {w3, w4, d};
		cyc(1);
		{ch3_wr_in, ch4_wr_in} = 2'b00;
	endtask
	task automatic clr_flags();
		flag_clear_in = 5'h1F;
		cyc(1);
		flag_clear_in = 5'h00;
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// comparing process: oldest note first
	// ----------------------------------------------------------------
	initial
	begin
		note_t n;
		forever
		begin
			@(seen_ev);
			while (notes.size() > 0)
			begin
				n = notes.pop_front();
				comparisons++;
				if (obs(n.sel, n.v) !== n.exp)
				begin
					fail_count++;
					$display("[FAIL] %s v%0d expected %h seen %h", what[n.sel], n.v, n.exp,
						obs(n.sel, n.v));
				end
			end
		end
	end
	// ----------------------------------------------------------------
	// main sequence, inputs change on the falling edge
	// ----------------------------------------------------------------
	initial
	begin
		logic [15:0] rb;
		void'($urandom(73063));
		{reset_in, mode_in, ch3_start_bit_in, ch4_start_bit_in, ch3_sync_bit_in} = 6'h20;
		{ch4_sync_bit_in, ch3_wr_in, ch4_wr_in, chop_en_in, chop_carrier_in} = 5'h00;
		{positive_phase_level_select_in, negative_phase_level_select_in} = 2'b11;
		{ch3_control_register_in, ch4_control_register_in, flag_clear_in} = 15'h0000;
		{ch3_period_register_in, ch4_compare_in, ch3_duty_register_in} = 48'h0;
		{ch3_duty_buffer_in, dead_time_value_in, wr_data_in} = 48'h0;
		{ch3_io_control_high_in, ch3_io_control_low_in} = 16'h0000;
		{ch4_io_control_high_in, ch4_io_control_low_in} = 16'h0000;
		cyc(8);
		note(5, 16'h003F, 16'h003F);
		reset_in = 1'b0;
		// compare clear gives a period of N+1 states
		ch3_control_register_in = {CLR_PERIOD, 1'b0, CLK_DIV1};
		ch3_period_register_in = 16'h0002;
		ch3_start_bit_in = 1'b1;
		for (int i = 1; i <= 4; i++)
		begin
			cyc(1);
			note(0, 16'(i % 3), 16'(i % 3));
		end
		// wrap without clear sets overflow; with clear it does not
		for (int k = 0; k < 2; k++)
		begin
			ch3_start_bit_in = 1'b0;
			ch3_period_register_in = 16'hFFFF;
			ch3_control_register_in = {(k == 1) ? CLR_PERIOD : CLR_NONE, 1'b0, CLK_DIV1};
			clr_flags();
			wr(1'b1, 1'b0, 16'hFFFE);
			ch3_start_bit_in = 1'b1;
			cyc(2);
			note(0, 16'h0000, 16'h0000);
			note(2, 16'(1 - k), 16'(1 - k));
		end
		// a write in the same cycle as a wrapping count wins, no flag
		ch3_start_bit_in = 1'b0;
		ch3_control_register_in = {CLR_NONE, 1'b0, CLK_DIV1};
		wr(1'b1, 1'b0, 16'hFFFF);
		clr_flags();
		ch3_start_bit_in = 1'b1;
		wr(1'b1, 1'b0, 16'h1234);
		note(0, 16'h1234, 16'h1234);
		note(2, 16'h0000, 16'h0000);
		cyc(1);
		note(0, 16'h1235, 16'h1235);
		// pins driven high, then low last, by the i/o nibbles in normal mode
		for (int k = 0; k < 2; k++)
		begin
			{ch3_io_control_high_in, ch3_io_control_low_in} = {2{8'h22 >> k}};
			{ch4_io_control_high_in, ch4_io_control_low_in} = {2{8'h22 >> k}};
			cyc(2);
			note(4, 16'((1 - k) * 63), 16'((1 - k) * 63));
			note(5, 16'h0000, 16'h0000);
		end
		{ch3_io_control_high_in, ch3_io_control_low_in} = 16'h0000;
		{ch4_io_control_high_in, ch4_io_control_low_in} = 16'h0000;
		// reset-sync at period all ones, ch4 runs on ch3 clocking
		ch3_start_bit_in = 1'b0;
		mode_in = MODE_RSYNC; // entered from normal mode only
		ch3_control_register_in = {CLR_PERIOD, 1'b0, CLK_DIV1};
		for (int k = 0; k < 2; k++)
		begin
			{ch3_sync_bit_in, ch4_sync_bit_in} = {2{k == 1}};
			ch4_control_register_in = {(k == 1) ? CLR_SYNC : CLR_NONE, 1'b0, CLK_DIV64};
			ch3_start_bit_in = 1'b0;
			clr_flags();
			wr(1'b1, 1'b1, 16'hFFFE);
			ch3_start_bit_in = 1'b1;
			cyc(1);
			note(1, 16'hFFFF, 16'hFFFF);
			cyc(1);
			note(1, 16'h0000, 16'h0000);
			note(2, (k == 1) ? 16'h0000 : 16'h0002, 16'h0000);
		end
		// output polarity from the level selects over one 21-state period
		ch3_period_register_in = 16'h0014;
		ch3_duty_register_in = 16'h000A;
		for (int p = 0; p < 4; p++)
		begin
			{negative_phase_level_select_in, positive_phase_level_select_in} = 2'(p);
			cyc(30);
			tally[0] = 16'h0000;
			tally[1] = 16'h0000;
			// high states of pins 0 and 3 over one period, counted per variant
			repeat (21)
			begin
				for (int v = 0; v < 2; v++)
					tally[v] += {7'h00, pin_o[v][3], 7'h00, pin_o[v][0]};
				cyc(1);
			end
			rb = {(p > 1) ? 8'h0A : 8'h0B, p[0] ? 8'h0B : 8'h0A};
			note(7, rb, rb);
			note(5, 16'h0000, 16'h0000);
		end
		// chopping with high-active outputs: a low carrier gates every pin low
		chop_en_in = 1'b1;
		cyc(2);
		note(4, 16'h0000, 16'h0000);
		chop_en_in = 1'b0;
		// complementary: dead-time related buffer values miss on base only
		mode_in = MODE_COMPL;
		dead_time_value_in = 16'h0004;
		for (int b = 0; b < 5; b++)
		begin
			rb = (b < 4) ? 16'(4 * (b + 1)) : 16'(17 + $urandom_range(2));
			ch3_start_bit_in = 1'b0;
			ch3_duty_buffer_in = rb;
			cyc(2);
			clr_flags();
			ch3_start_bit_in = 1'b1;
			cyc(6);
			note(8, 16'h0004, 16'h0004);
			cyc(14);
			// a write of zero while counting down makes ch4 underflow next tick
			if (b == 4)
			begin
				wr(1'b0, 1'b1, 16'h0000);
				cyc(1);
				note(6, 16'h0002, 16'h0002);
			end
			cyc(30);
			note(3, (b < 4) ? 16'h0000 : 16'h0001, 16'h0001);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
